// ---- hdl/trig_cap_pkg.sv ----
/*
  Shared constants and types of the trigger and capture core.
  Assumes a single 100 MHz master sample clock for all logic.
*/
package trig_cap_pkg;
  localparam int CH_PER_BOARD = 16;
  localparam int PROBE_W = 8;
  localparam int PROBES = 2;
  localparam int LEVEL_W = 4;
  localparam int COND_W = 4;
  localparam int GROUP_AW = 11;
  localparam int GROUP_DEPTH = 2048;
  localparam int OCC_W = 16;
  localparam int FILT_W = 4;
  localparam int TB_W = 16;
  localparam int CRAM_AW = CH_PER_BOARD + LEVEL_W;
  localparam int COND_FIRST = 0;
  localparam int COND_JUMP = 1;
  localparam int MCLK_PERIOD_PS = 10000;
  localparam int MEM_CYCLE_NS = 20;
  localparam int MEM_CYCLE_CYC = (MEM_CYCLE_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam logic [TB_W-1:0] TB_MIN_PERIOD = TB_W'(MEM_CYCLE_CYC);
  localparam logic [TB_W-1:0] TB_ONE = 16'h0001;
  localparam logic [1:0] TRANS_ZERO = 2'h0;
  localparam logic [1:0] TRANS_MANY = 2'h2;
  localparam logic [OCC_W-1:0] OCC_ONE = 16'h0001;
  localparam logic [FILT_W-1:0] FILT_ZERO = 4'h0;
  localparam logic [FILT_W-1:0] FILT_ONE = 4'h1;
  localparam logic [LEVEL_W-1:0] LEVEL_START = 4'h0;
  localparam logic [LEVEL_W-1:0] LEVEL_ONE = 4'h1;
  typedef enum logic [1:0] {
    REC_NORMAL = 2'b00,
    REC_QUALIFIED = 2'b01,
    REC_TRANSITION = 2'b10
  } rec_mode_t;
endpackage : trig_cap_pkg

// ---- hdl/trigger_capture_core.sv ----
/*
  Capture boards (sampling, condition RAM, spike and change detect, capture
  memory) and the sequencer front end (filter, occurrence counter, level counter).
  Assumes probe and external clock pins are asynchronous; all else is on i_mclk.
*/
//
// Contract
// - non-interleaved: sample 16 channels each board tick, up to 50 MS/s, 2K deep
// - interleaved: lower probe only, 4K deep, up to 100 MS/s
// - interleave only with internal time base, never external clock
// - sampled word addresses condition RAM, 4 condition bits out
// - level select lines are extra condition RAM address bits
// - combined condition bit true only when true on every board
// - glitch means more than one transition in one sample period
// - glitch probe: even channels data, odd channels glitch flags
// - spike on any glitch, ORed over boards; glitch mode non-interleaved only
// - per-probe transition detect gives change strobe, ORed over boards
// - write sample only while that board's capture accept is true
// - qualified and transition recording only in non-interleaved mode
// - two 8-bit x 2K groups: parallel, or alternating in interleave
// - sequencer decisions all on the master sample clock
// - bits 0 and 1 checked together; bit 1 wins and jumps
// - per-level spike substitute replaces condition bit 0
// - filter accepts after 1 to 15 clocks true, one-clock pulse
// - filter length and enables stored per trigger level
// - after bit 0 accepted, blocked until it goes false then true
// - 16-bit loadable occurrence counter releases bit 0 at programmed count
// - delay mode: filter off, bit 0 true, count clocks then advance
// - occurrence mode: filter on, count occurrences then advance
// - 4-bit level counter: increment on advance, load destination on jump
// - interleave blocks board clock; two phases at half rate, opposite
`timescale 1ns/1ps
module trigger_capture_core #(
  parameter int NB = 4
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [NB-1:0][trig_cap_pkg::CH_PER_BOARD-1:0] i_probe_data,
  input wire logic [NB-1:0] i_ext_rec_clk,
  input wire logic [NB-1:0] i_ext_clk_sel,
  input wire logic [NB-1:0] i_interleave,
  input wire logic [NB-1:0][trig_cap_pkg::PROBES-1:0] i_glitch_mode,
  input wire logic [NB-1:0][trig_cap_pkg::PROBES-1:0] i_transition_mode,
  input wire logic [trig_cap_pkg::TB_W-1:0] i_tb_period,
  input wire trig_cap_pkg::rec_mode_t i_record_mode,
  input wire logic [NB-1:0] i_capture_accept_n,
  input wire logic i_search_en,
  input wire logic i_cram_we,
  input wire logic [$clog2(NB)-1:0] i_cram_board,
  input wire logic [trig_cap_pkg::CRAM_AW-1:0] i_cram_addr,
  input wire logic [trig_cap_pkg::COND_W-1:0] i_cram_data,
  input wire logic i_lvl_we,
  input wire logic [trig_cap_pkg::LEVEL_W-1:0] i_lvl_addr,
  input wire logic [trig_cap_pkg::LEVEL_W-1:0] i_lvl_dest,
  input wire logic [trig_cap_pkg::OCC_W-1:0] i_lvl_occ,
  input wire logic [trig_cap_pkg::FILT_W-1:0] i_lvl_filt,
  input wire logic i_lvl_filter_enable_cond0,
  input wire logic i_lvl_filter_enable_cond1,
  input wire logic i_lvl_spike_substitute_enable,
  input wire logic i_lvl_delay_mode,
  input wire logic [$clog2(NB)-1:0] i_rd_board,
  input wire logic [trig_cap_pkg::GROUP_AW:0] i_rd_addr,
  output logic [trig_cap_pkg::CH_PER_BOARD-1:0] o_rd_data,
  output logic [NB-1:0][trig_cap_pkg::GROUP_AW:0] o_wr_addr,
  output logic [trig_cap_pkg::COND_W-1:0] o_cond_bus,
  output logic o_spike_event,
  output logic o_change_strobe,
  output logic [trig_cap_pkg::LEVEL_W-1:0] o_level_select_lines,
  output logic o_advance_level,
  output logic [NB-1:0] o_interleave_block,
  output logic [NB-1:0] o_interleave_phase_a,
  output logic [NB-1:0] o_interleave_phase_b,
  output logic [NB-1:0] o_config_error
);
  import trig_cap_pkg::*;

  localparam int CH = CH_PER_BOARD;
  localparam int AW = GROUP_AW + 1;

  function automatic logic [1:0] sat_inc(input logic [1:0] c, input logic inc);
    sat_inc = (inc && c != TRANS_MANY) ? c + 2'h1 : c;
  endfunction : sat_inc

  // glitch-mode probes keep even channels and put each even channel's glitch on the odd one
  function automatic logic [CH-1:0] build_word(input logic [CH-1:0] d, input logic [CH-1:0] g,
                                               input logic [PROBES-1:0] gm, input logic il);
    logic [CH-1:0] w;
    w = d;
    for (int i = 0; i < CH; i += 2) begin
      if (gm[i / PROBE_W]) begin
        w[i + 1] = g[i];
      end
    end
    if (il) begin
      w[CH-1:PROBE_W] = '0;
    end
    build_word = w;
  endfunction : build_word

  logic [NB-1:0][CH-1:0] pr_s1_r, pr_s2_r, pr_s3_r, last_raw_r, samp_r;
  logic [NB-1:0] ext_s1_r, ext_s2_r, ext_s3_r;
  logic [NB-1:0][CH-1:0][1:0] tcnt_r;
  logic [TB_W-1:0] tb_cnt_r;
  logic tb_tick_r, half_ph_r;
  logic [NB-1:0] il_eff, btick, mode_ok, wr_r;
  logic [NB-1:0][CH-1:0] gl_now;
  logic [NB-1:0] spike_b, change_b;
  logic [NB-1:0][COND_W-1:0] cond_b;
  logic [COND_W-1:0] cond_all;
  logic [COND_W-1:0] cram_m [NB][2**CRAM_AW];
  logic [PROBE_W-1:0] grp_lo_m [NB][GROUP_DEPTH];
  logic [PROBE_W-1:0] grp_hi_m [NB][GROUP_DEPTH];

  // pin inputs pass two flip-flops; stage 3 only feeds external clock edge detection and transition counting
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      pr_s1_r <= '0;
      pr_s2_r <= '0;
      pr_s3_r <= '0;
      ext_s1_r <= '0;
      ext_s2_r <= '0;
      ext_s3_r <= '0;
    end else begin
      pr_s1_r <= i_probe_data;
      pr_s2_r <= pr_s1_r;
      pr_s3_r <= pr_s2_r;
      ext_s1_r <= i_ext_rec_clk;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
    end
  end

  // internal time base: one tick every i_tb_period master clocks
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      tb_cnt_r <= '0;
      tb_tick_r <= 1'b0;
      half_ph_r <= 1'b0;
    end else begin
      tb_tick_r <= (tb_cnt_r + TB_ONE >= i_tb_period);
      tb_cnt_r <= (tb_cnt_r + TB_ONE >= i_tb_period) ? '0 : tb_cnt_r + TB_ONE;
      if (tb_tick_r) begin
        half_ph_r <= ~half_ph_r;
      end
    end
  end

  always_comb begin
    cond_all = '1;
    for (int b = 0; b < NB; b++) begin
      il_eff[b] = i_interleave[b] & ~i_ext_clk_sel[b];
      mode_ok[b] = ~il_eff[b] | (i_record_mode == REC_NORMAL);
      if (i_ext_clk_sel[b]) begin
        btick[b] = ext_s2_r[b] & ~ext_s3_r[b];
      end else if (il_eff[b] || i_tb_period >= TB_MIN_PERIOD) begin
        btick[b] = tb_tick_r;
      end else begin
        btick[b] = tb_tick_r & half_ph_r;
      end
      for (int c = 0; c < CH; c++) begin
        gl_now[b][c] = sat_inc(tcnt_r[b][c], pr_s2_r[b][c] ^ pr_s3_r[b][c]) == TRANS_MANY;
      end
      spike_b[b] = 1'b0;
      change_b[b] = 1'b0;
      for (int p = 0; p < PROBES; p++) begin
        if (i_glitch_mode[b][p] && !il_eff[b]) begin
          spike_b[b] |= btick[b] & (|gl_now[b][p*PROBE_W +: PROBE_W]);
        end
        if (i_transition_mode[b][p] && !(il_eff[b] && p != 0)) begin
          change_b[b] |= btick[b] &
            (|(pr_s2_r[b][p*PROBE_W +: PROBE_W] ^ last_raw_r[b][p*PROBE_W +: PROBE_W]));
        end
      end
      cond_b[b] = cram_m[b][{o_level_select_lines, samp_r[b]}];
      cond_all &= cond_b[b];
    end
  end

  // transition counting per sample period and the input register
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      tcnt_r <= '0;
      last_raw_r <= '0;
      samp_r <= '0;
      wr_r <= '0;
    end else begin
      for (int b = 0; b < NB; b++) begin
        for (int c = 0; c < CH; c++) begin
          tcnt_r[b][c] <= btick[b] ? TRANS_ZERO
                        : sat_inc(tcnt_r[b][c], pr_s2_r[b][c] ^ pr_s3_r[b][c]);
        end
        if (btick[b]) begin
          last_raw_r[b] <= pr_s2_r[b];
          samp_r[b] <= build_word(pr_s2_r[b], gl_now[b],
                                  il_eff[b] ? '0 : i_glitch_mode[b], il_eff[b]);
        end
        wr_r[b] <= btick[b] & ~i_capture_accept_n[b] & mode_ok[b];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_cram_we) begin
      cram_m[i_cram_board][i_cram_addr] <= i_cram_data;
    end
  end

  // capture memory: groups in parallel, or one group per interleave phase
  always_ff @(posedge i_mclk) begin
    for (int b = 0; b < NB; b++) begin
      if (wr_r[b] && !il_eff[b]) begin
        grp_lo_m[b][o_wr_addr[b][GROUP_AW-1:0]] <= samp_r[b][PROBE_W-1:0];
        grp_hi_m[b][o_wr_addr[b][GROUP_AW-1:0]] <= samp_r[b][CH-1:PROBE_W];
      end else if (wr_r[b] && !o_wr_addr[b][0]) begin
        grp_lo_m[b][o_wr_addr[b][AW-1:1]] <= samp_r[b][PROBE_W-1:0];
      end else if (wr_r[b]) begin
        grp_hi_m[b][o_wr_addr[b][AW-1:1]] <= samp_r[b][PROBE_W-1:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_wr_addr <= '0;
    end else begin
      for (int b = 0; b < NB; b++) begin
        if (wr_r[b]) begin
          o_wr_addr[b] <= il_eff[b] ? o_wr_addr[b] + 1'b1
                        : {1'b0, o_wr_addr[b][GROUP_AW-1:0] + 1'b1};
        end
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_rd_data <= '0;
    end else if (!il_eff[i_rd_board]) begin
      o_rd_data <= {grp_hi_m[i_rd_board][i_rd_addr[GROUP_AW-1:0]],
                    grp_lo_m[i_rd_board][i_rd_addr[GROUP_AW-1:0]]};
    end else begin
      o_rd_data <= {{PROBE_W{1'b0}}, i_rd_addr[0] ? grp_hi_m[i_rd_board][i_rd_addr[AW-1:1]]
                                                  : grp_lo_m[i_rd_board][i_rd_addr[AW-1:1]]};
    end
  end

  // shared bus view of the boards and interleave clock outputs
  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      o_cond_bus <= '0;
      o_spike_event <= 1'b0;
      o_change_strobe <= 1'b0;
      o_interleave_block <= '0;
      o_interleave_phase_a <= '0;
      o_interleave_phase_b <= '0;
      o_config_error <= '0;
    end else begin
      o_cond_bus <= cond_all;
      o_spike_event <= |spike_b;
      o_change_strobe <= |change_b;
      o_interleave_block <= il_eff;
      o_interleave_phase_a <= il_eff & {NB{tb_tick_r & ~half_ph_r}};
      o_interleave_phase_b <= il_eff & {NB{tb_tick_r & half_ph_r}};
      for (int b = 0; b < NB; b++) begin
        o_config_error[b] <= (i_interleave[b] & i_ext_clk_sel[b]) | ~mode_ok[b]
                           | (il_eff[b] & (|i_glitch_mode[b]));
      end
    end
  end

  // ---- sequencer, all on the master sample clock ----
  logic [LEVEL_W-1:0] lv_dest_m [2**LEVEL_W];
  logic [OCC_W-1:0] lv_occ_m [2**LEVEL_W];
  logic [FILT_W-1:0] lv_filt_m [2**LEVEL_W];
  logic [2**LEVEL_W-1:0] lv_f0_m, lv_f1_m, lv_spk_m, lv_dly_m;
  logic [1:0][FILT_W-1:0] fcnt_r;
  logic [1:0] fblk_r, raw, fen, acc;
  logic [OCC_W-1:0] occ_r;
  logic blank_r, adv_nxt;
  logic [LEVEL_W-1:0] lvl, lvl_nxt;
  logic [FILT_W-1:0] flen;

  assign lvl = o_level_select_lines;

  always_ff @(posedge i_mclk) begin
    if (i_lvl_we) begin
      lv_dest_m[i_lvl_addr] <= i_lvl_dest;
      lv_occ_m[i_lvl_addr] <= i_lvl_occ;
      lv_filt_m[i_lvl_addr] <= i_lvl_filt;
      lv_f0_m[i_lvl_addr] <= i_lvl_filter_enable_cond0;
      lv_f1_m[i_lvl_addr] <= i_lvl_filter_enable_cond1;
      lv_spk_m[i_lvl_addr] <= i_lvl_spike_substitute_enable;
      lv_dly_m[i_lvl_addr] <= i_lvl_delay_mode;
    end
  end

  always_comb begin
    flen = (lv_filt_m[lvl] == FILT_ZERO) ? FILT_ONE : lv_filt_m[lvl];
    raw[COND_FIRST] = lv_dly_m[lvl] | (lv_spk_m[lvl] ? o_spike_event
                                                    : o_cond_bus[COND_FIRST]);
    raw[COND_JUMP] = o_cond_bus[COND_JUMP];
    fen[COND_FIRST] = lv_f0_m[lvl] & ~lv_dly_m[lvl];
    fen[COND_JUMP] = lv_f1_m[lvl];
    for (int k = 0; k < 2; k++) begin
      if (blank_r || !i_search_en) begin
        acc[k] = 1'b0;
      end else if (k == COND_FIRST && lv_dly_m[lvl]) begin
        acc[k] = 1'b1;
      end else if (fen[k]) begin
        acc[k] = raw[k] & ~fblk_r[k] & (fcnt_r[k] + FILT_ONE >= flen);
      end else begin
        acc[k] = raw[k] & ~fblk_r[k];
      end
    end
    adv_nxt = acc[COND_FIRST] & (occ_r <= OCC_ONE);
    if (acc[COND_JUMP]) begin
      lvl_nxt = lv_dest_m[lvl];
    end else if (adv_nxt) begin
      lvl_nxt = lvl + LEVEL_ONE;
    end else begin
      lvl_nxt = lvl;
    end
  end

  // filters hold the true time and the once-per-occurrence block
  always_ff @(posedge i_mclk) begin
    if (!i_rstn || blank_r) begin
      fcnt_r <= '0;
      fblk_r <= '0;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (!raw[k]) begin
          fcnt_r[k] <= FILT_ZERO;
          fblk_r[k] <= 1'b0;
        end else begin
          if (fcnt_r[k] != '1) begin
            fcnt_r[k] <= fcnt_r[k] + FILT_ONE;
          end
          if (acc[k] && !(k == COND_FIRST && lv_dly_m[lvl])) begin
            fblk_r[k] <= 1'b1;
          end
        end
      end
    end
  end

  // level counter, occurrence counter and one blank clock after each level change
  always_ff @(posedge i_mclk) begin
    if (!i_rstn || !i_search_en) begin
      o_level_select_lines <= LEVEL_START;
      o_advance_level <= 1'b0;
      occ_r <= OCC_ONE;
      blank_r <= 1'b1;
    end else begin
      o_level_select_lines <= lvl_nxt;
      o_advance_level <= adv_nxt & ~acc[COND_JUMP];
      blank_r <= acc[COND_JUMP] | adv_nxt;
      if (blank_r) begin
        occ_r <= lv_occ_m[lvl];
      end else if (acc[COND_FIRST] && !adv_nxt) begin
        occ_r <= occ_r - OCC_ONE;
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence jump_taken_s;
    acc[COND_JUMP] ##1 1'b1;
  endsequence

  jump_dest_a: assert property (acc[COND_JUMP] |=> lvl == $past(lv_dest_m[lvl]))
    else $error("jump did not load destination");
  jump_wins_a: assert property (acc[COND_JUMP] && adv_nxt |-> jump_taken_s ##0 !o_advance_level)
    else $error("bit 0 advanced while bit 1 jumped");
  level_inc_a: assert property (adv_nxt && !acc[COND_JUMP] && i_search_en
                                |=> lvl == $past(lvl) + LEVEL_ONE)
    else $error("advance did not increment level");
  cond_and_a: assert property (((o_cond_bus & ~$past(cond_b[0])) == '0)
                               && ((o_cond_bus & ~$past(cond_b[NB-1])) == '0))
    else $error("combined condition not AND of boards");
  phase_apart_a: assert property (!(|(o_interleave_phase_a & o_interleave_phase_b)))
    else $error("interleave phases overlap");
  ext_no_il_a: assert property (|(o_interleave_block & $past(i_ext_clk_sel))
                                |-> 1'b0)
    else $error("interleave with external clock");
  write_gate_a: assert property (wr_r[0] |-> $past(!i_capture_accept_n[0] && btick[0]))
    else $error("sample written without capture accept");
  occ_release_a: assert property (o_advance_level |-> $past(occ_r <= OCC_ONE && acc[COND_FIRST]))
    else $error("advance before occurrence count reached");
  once_per_occ_a: assert property (acc[COND_FIRST] && !lv_dly_m[lvl] && !adv_nxt && !acc[COND_JUMP]
                                   |=> !acc[COND_FIRST])
    else $error("bit 0 accepted twice in one occurrence");
endmodule : trigger_capture_core

// ---- verif/probe_source.sv ----
/*
  Probe source: behavioural stand-in for the probed system under test.
  Assumes the bench calls its tasks just after a falling edge of i_mclk.
*/
`timescale 1ns/1ps
module probe_source #(
  parameter int NB = 2
) (
  input wire logic i_mclk,
  output logic [NB-1:0][15:0] o_probe_data,
  output logic [NB-1:0] o_ext_rec_clk
);
  initial begin
    o_probe_data = '0;
    o_ext_rec_clk = '0;
  end

  task automatic set_word(input int b, input logic [15:0] w);
    o_probe_data[b] = w;
  endtask : set_word

  // two edges on one channel, two master clocks apart
  task automatic pulse_ch(input int b, input int ch);
    o_probe_data[b][ch] = ~o_probe_data[b][ch];
    repeat (2) @(negedge i_mclk);
    o_probe_data[b][ch] = ~o_probe_data[b][ch];
  endtask : pulse_ch
endmodule : probe_source

// ---- verif/trigger_capture_core_tb.sv ----
/*
  Self-checking bench for the trigger and capture core, two boards.
  Assumes the probe source model drives the probe and external clock pins; all else is driven here.
*/
`timescale 1ns/1ps
module trigger_capture_core_tb;
  import trig_cap_pkg::*;
  localparam int NB = 2;
  localparam logic [15:0] WA = 16'h00a5;
  localparam logic [15:0] WB = 16'h0f0f;
  localparam logic [FILT_W-1:0] FL = 4'h3;
  logic i_mclk, i_rstn, search_en, cram_we, lvl_we, f0, f1, sse, dly, spike, chg, adv;
  logic [NB-1:0][CH_PER_BOARD-1:0] probe;
  logic [NB-1:0] ext_clk, ext_sel, ilv, acc_n, cfg_err, il_blk, ph_a, ph_b;
  logic [NB-1:0][PROBES-1:0] gm, tm;
  logic [TB_W-1:0] tb_per;
  rec_mode_t rmode;
  logic [0:0] cram_b, rd_b;
  logic [CRAM_AW-1:0] cram_a;
  logic [COND_W-1:0] cram_d, cond;
  logic [LEVEL_W-1:0] lvl_a, lvl_d, lvl;
  logic [OCC_W-1:0] occ;
  logic [FILT_W-1:0] filt;
  logic [GROUP_AW:0] rd_a;
  logic [CH_PER_BOARD-1:0] rd_d;
  logic [NB-1:0][GROUP_AW:0] wr_a;
  int n_fail, comparisons;

  probe_source #(.NB(NB)) psrc (.i_mclk(i_mclk), .o_probe_data(probe), .o_ext_rec_clk(ext_clk));

  trigger_capture_core #(.NB(NB)) dut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_probe_data(probe), .i_ext_rec_clk(ext_clk),
    .i_ext_clk_sel(ext_sel), .i_interleave(ilv), .i_glitch_mode(gm), .i_transition_mode(tm),
    .i_tb_period(tb_per), .i_record_mode(rmode), .i_capture_accept_n(acc_n),
    .i_search_en(search_en), .i_cram_we(cram_we), .i_cram_board(cram_b), .i_cram_addr(cram_a),
    .i_cram_data(cram_d), .i_lvl_we(lvl_we), .i_lvl_addr(lvl_a), .i_lvl_dest(lvl_d),
    .i_lvl_occ(occ), .i_lvl_filt(filt), .i_lvl_filter_enable_cond0(f0),
    .i_lvl_filter_enable_cond1(f1), .i_lvl_spike_substitute_enable(sse), .i_lvl_delay_mode(dly),
    .i_rd_board(rd_b), .i_rd_addr(rd_a), .o_rd_data(rd_d), .o_wr_addr(wr_a), .o_cond_bus(cond),
    .o_spike_event(spike), .o_change_strobe(chg), .o_level_select_lines(lvl),
    .o_advance_level(adv), .o_interleave_block(il_blk), .o_interleave_phase_a(ph_a),
    .o_interleave_phase_b(ph_b), .o_config_error(cfg_err)
  );

  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  task automatic cram_wr(input logic b, input logic [3:0] l, input logic [15:0] w,
                         input logic [3:0] d);
    cram_b = b;
    cram_a = {l, w};
    cram_d = d;
    cram_we = 1'b1;
    @(negedge i_mclk);
    cram_we = 1'b0;
  endtask : cram_wr

  task automatic lvl_wr(input logic [3:0] l, input logic [3:0] d, input logic [15:0] o,
                        input logic [3:0] fl);
    lvl_a = l;
    lvl_d = d;
    occ = o;
    filt = fl;
    lvl_we = 1'b1;
    @(negedge i_mclk);
    lvl_we = 1'b0;
  endtask : lvl_wr

  // increment after filter, then a jump that must beat the increment
  task automatic t_seq();
    int n;
    int k;
    logic saw;
    n = 0;
    k = 0;
    saw = 1'b0;
    psrc.set_word(0, WA);
    psrc.set_word(1, WA);
    while (lvl === LEVEL_START && k < 40) begin
      @(negedge i_mclk);
      k++;
      if (cond[COND_FIRST] === 1'b1 && lvl === LEVEL_START) n++;
      if (adv === 1'b1) saw = 1'b1;
    end
    chk(lvl, LEVEL_ONE, "level after increment");
    chk(n, FL, "filter length");
    chk(saw, 1'b1, "advance pulse");
    saw = 1'b0;
    k = 0;
    while (lvl === LEVEL_ONE && k < 40) begin
      @(negedge i_mclk);
      k++;
      if (adv === 1'b1) saw = 1'b1;
    end
    chk(lvl, 4'h5, "level after jump");
    chk(saw, 1'b0, "no advance on jump");
  endtask : t_seq

  task automatic t_cond_and();
    psrc.set_word(0, WB);
    psrc.set_word(1, WB);
    repeat (8) @(negedge i_mclk);
    chk(cond, 4'h0, "bit true on one board only");
    cram_wr(1'b1, 4'h5, WB, 4'h4);
    repeat (3) @(negedge i_mclk);
    chk(cond, 4'h4, "bit true on all boards");
  endtask : t_cond_and

  task automatic t_capture();
    logic [GROUP_AW:0] a0;
    logic [GROUP_AW:0] a1;
    logic [GROUP_AW:0] d;
    int k;
    psrc.set_word(0, WA);
    acc_n = 2'b10;
    repeat (4) @(negedge i_mclk);
    a0 = wr_a[0];
    a1 = wr_a[1];
    repeat (40) @(negedge i_mclk);
    d = wr_a[0] - a0;
    chk(wr_a[1], a1, "refused board wrote");
    chk(d >= 12'h013 && d <= 12'h015, 1'b1, "writes at half rate");
    rd_b = 1'b0;
    rd_a = wr_a[0] - 12'h001;
    repeat (2) @(negedge i_mclk);
    chk(rd_d, WA, "stored word");
    k = 0;
    while (wr_a[0] !== 12'h000 && k < 5000) begin
      @(negedge i_mclk);
      k++;
    end
    chk(wr_a[0], 12'h000, "address wraps at 2K");
    acc_n = 2'b11;
  endtask : t_capture

  task automatic t_events();
    int k;
    tm[0] = 2'b01;
    psrc.set_word(0, WB);
    k = 0;
    while (chg !== 1'b1 && k < 10) begin
      @(negedge i_mclk);
      k++;
    end
    chk(chg, 1'b1, "change strobe");
    tm[0] = 2'b00;
    gm[0] = 2'b01;
    tb_per = 16'h0010;
    repeat (10) @(negedge i_mclk);
    k = 0;
    // repeated pulses shift against the tick, so one pair falls inside one period
    while (spike !== 1'b1 && k < 80) begin
      if (k % 22 == 0) psrc.pulse_ch(0, 2);
      @(negedge i_mclk);
      k++;
    end
    chk(spike, 1'b1, "spike event");
    gm[0] = 2'b00;
    tb_per = 16'h0001;
  endtask : t_events

  task automatic t_config();
    int pa;
    int pb;
    int both;
    pa = 0;
    pb = 0;
    both = 0;
    ilv = 2'b11;
    ext_sel = 2'b10;
    repeat (6) @(negedge i_mclk);
    chk(cfg_err, 2'b10, "interleave with external clock");
    chk(il_blk, 2'b01, "board clock blocked");
    repeat (8) begin
      @(negedge i_mclk);
      pa += int'(ph_a[0] === 1'b1);
      pb += int'(ph_b[0] === 1'b1);
      both += int'(ph_a[0] === 1'b1 && ph_b[0] === 1'b1);
    end
    chk(pa > 0 && pb > 0 && both == 0, 1'b1, "phases alternate");
    ilv = 2'b00;
    ext_sel = 2'b00;
  endtask : t_config

  initial begin
    n_fail = 0;
    comparisons = 0;
    {i_rstn, search_en, cram_we, lvl_we, sse, dly} = '0;
    {f0, f1} = 2'b11;
    {ext_sel, ilv, gm, tm, cram_b, rd_b, cram_a, cram_d, lvl_a, lvl_d, occ, filt, rd_a} = '0;
    acc_n = 2'b11;
    tb_per = 16'h0001;
    rmode = REC_NORMAL;
    repeat (6) @(negedge i_mclk);
    i_rstn = 1'b1;
    for (int b = 0; b < NB; b++) begin
      cram_wr(b[0], 4'h0, 16'h0000, 4'h0);
      cram_wr(b[0], 4'h1, 16'h0000, 4'h0);
      cram_wr(b[0], 4'h5, 16'h0000, 4'h0);
      cram_wr(b[0], 4'h0, WA, 4'h1);
      cram_wr(b[0], 4'h1, WA, 4'h3);
      cram_wr(b[0], 4'h5, WA, 4'h0);
      cram_wr(b[0], 4'h5, WB, (b == 0) ? 4'h4 : 4'h0);
    end
    lvl_wr(4'h0, 4'h0, OCC_ONE, FL);
    lvl_wr(4'h1, 4'h5, OCC_ONE, FILT_ONE);
    lvl_wr(4'h5, 4'h5, 16'hffff, FILT_ONE);
    search_en = 1'b1;
    t_seq();
    t_cond_and();
    t_capture();
    t_config();
    t_events();
    summarize();
  end

  initial begin
    #500000;
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end
endmodule : trigger_capture_core_tb
